// file: design/scl_pkg.sv
// constants and types of the synthesizer control block
package scl_pkg;

  // bus geometry
  localparam int unsigned SCL_AW = 8;
  localparam int unsigned SCL_DW = 32;

  // register indexes, byte address is four times the index
  localparam logic [5:0] SCL_IDX_CTRL = 6'h00;
  localparam logic [5:0] SCL_IDX_OSC = 6'h01;
  localparam logic [5:0] SCL_IDX_IRQ_STAT = 6'h02;
  localparam logic [5:0] SCL_IDX_IRQ_MASK = 6'h03;
  localparam logic [5:0] SCL_IDX_LOCK_CFG = 6'h04;
  localparam logic [5:0] SCL_IDX_STATUS = 6'h05;
  localparam logic [5:0] SCL_IDX_DIV_FIRST = 6'h06;
  localparam logic [5:0] SCL_IDX_DIV_LAST = 6'h0B;
  localparam logic [5:0] SCL_IDX_FREQ = 6'h0C;

  // control register fields
  localparam int unsigned SCL_CTRL_MODE_LSB = 0;
  localparam int unsigned SCL_CTRL_BAND_LSB = 3;
  localparam int unsigned SCL_CTRL_TRIM_LSB = 5;
  localparam int unsigned SCL_CTRL_SET_BIT = 7;
  localparam logic [7:0] SCL_CTRL_RESET = 8'h00;

  // oscillator register fields
  localparam int unsigned SCL_OSC_EN_BIT = 0;
  localparam int unsigned SCL_OSC_DIV_LSB = 1;
  localparam logic [3:0] SCL_OSC_RESET = 4'h1;

  // interrupt bits
  localparam int unsigned SCL_IRQ_LOCK = 0;
  localparam int unsigned SCL_IRQ_LOSS = 1;
  localparam int unsigned SCL_NIRQ = 2;

  // operating modes
  localparam logic [2:0] SCL_MODE_SLEEP = 3'h0;
  localparam logic [2:0] SCL_MODE_RX = 3'h3;

  // carrier arithmetic
  localparam logic [15:0] SCL_MAIN_MULT = 16'h004B;

  // bus answer state, one-hot
  typedef enum logic [2:0] {
    SCL_BUS_IDLE = 3'b001,
    SCL_BUS_FETCH = 3'b010,
    SCL_BUS_ACK = 3'b100
  } scl_bus_state_t;

  // software configuration
  typedef struct packed {
    logic set_sel;
    logic [1:0] tank_trim_field;
    logic [1:0] band_select_field;
    logic [2:0] operating_mode_field;
  } scl_ctrl_t;

  // one divider set
  typedef struct packed {
    logic [7:0] ref_div;
    logic [7:0] main_div;
    logic [7:0] fine_div;
  } scl_div_set_t;

  // what goes to the analog synthesizer
  typedef struct packed {
    logic [7:0] ref_div;
    logic [15:0] loop_count;
    logic [1:0] band_select_field;
    logic [1:0] tank_trim_field;
  } scl_synth_cfg_t;

  // loop multiplier 75*(main+1)+fine
  function automatic logic [15:0] scl_loop_count(input logic [7:0] main_div,
                                                  input logic [7:0] fine_div);
    logic [15:0] prod;
    prod = SCL_MAIN_MULT * ({8'h00, main_div} + 16'h0001);
    return prod + {8'h00, fine_div};
  endfunction : scl_loop_count

endpackage : scl_pkg

// file: design/scl_clkout_div.sv
// enable pulse generator for the reference clock output
`timescale 1ns/1ps
`default_nettype none
module scl_clkout_div (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // control
  input wire logic run,
  input wire logic [2:0] ratio_sel,
  // pulse out
  output logic tick
);
  import scl_pkg::*;

  logic [7:0] count_q;
  logic [7:0] limit;

  // terminal count is 2^sel - 1
  assign limit = 8'((9'h001 << ratio_sel) - 9'h001);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= 8'h00;
      tick <= 1'b0;
    end else if (!run) begin
      count_q <= 8'h00;
      tick <= 1'b0;
    end else if (count_q >= limit) begin
      count_q <= 8'h00;
      tick <= 1'b1;
    end else begin
      count_q <= count_q + 8'h01;
      tick <= 1'b0;
    end
  end

endmodule : scl_clkout_div
`default_nettype wire

// file: design/scl_div_mem.sv
// store for the two divider sets
`timescale 1ns/1ps
`default_nettype none
module scl_div_mem (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // bus side
  input wire logic wr_en,
  input wire logic [2:0] addr,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data,
  // active set
  input wire logic set_sel,
  output scl_pkg::scl_div_set_t active_set
);
  import scl_pkg::*;

  logic [7:0] mem_q [0:5];

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 6; i++) begin
        mem_q[i] <= 8'h00;
      end
    end else if (wr_en && addr < 3'h6) begin
      mem_q[addr] <= wr_data;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rd_data <= 8'h00;
      active_set <= '0;
    end else begin
      rd_data <= (addr < 3'h6) ? mem_q[addr] : 8'h00;
      if (set_sel) begin
        active_set <= '{mem_q[3], mem_q[4], mem_q[5]};
      end else begin
        active_set <= '{mem_q[0], mem_q[1], mem_q[2]};
      end
    end
  end

endmodule : scl_div_mem
`default_nettype wire

// file: design/scl_synth_ctrl.sv
// synthesizer configuration and lock status block
//
// Behaviour
// - when enabled, clock pin carries the reference divided by the chosen ratio.
// - clock output is on after reset and stopped in sleep mode; reset also selects sleep, so the pin stays low until the mode is written.
// - lock flag readable; writing one clears it, writing zero keeps it.
// - with lock pin enabled, the lock pin shows synthesizer lock status.
// - two sets of reference, main and fine dividers at indexes 6 to 11.
// - carrier is 9/8 of crystal over (ref+1) times (75(main+1)+fine).
// - operating mode 011 puts the device in receive operation.
//
// Chosen here: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module scl_synth_ctrl (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [scl_pkg::SCL_AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [scl_pkg::SCL_DW-1:0] wb_dat_i,
  output logic [scl_pkg::SCL_DW-1:0] wb_dat_o,
  output logic wb_ack_o,
  // synthesizer
  input wire logic synth_lock_raw,
  output scl_pkg::scl_synth_cfg_t synth_cfg,
  output logic rx_enable,
  output logic sleep_mode,
  // pins
  output logic clk_out,
  output logic lock_pin,
  // interrupt
  output logic irq
);
  import scl_pkg::*;

  ////////////////////////////////////////////////////////////
  // declarations

  scl_bus_state_t bus_q;
  scl_bus_state_t bus_d;
  logic [5:0] idx_q;
  logic we_q;
  logic [31:0] wdat_q;
  logic lane0_q;
  logic [31:0] rdat;
  logic wr_hit;

  scl_ctrl_t ctrl_q;
  logic osc_en_q;
  logic [2:0] osc_div_q;
  logic lock_pin_en_q;
  logic [SCL_NIRQ-1:0] irq_stat_q;
  logic [SCL_NIRQ-1:0] irq_mask_q;
  logic [SCL_NIRQ-1:0] irq_evt;
  logic [SCL_NIRQ-1:0] irq_clr;

  logic lock_meta_q;
  logic lock_sync_q;
  logic lock_prev_q;

  logic mem_wr;
  logic [5:0] mem_idx;
  logic [2:0] mem_addr;
  logic [7:0] mem_rd;
  scl_div_set_t act_set;
  logic clk_run;
  logic clk_tick;

  // divider byte index test
  function automatic logic in_div_range(input logic [5:0] idx);
    return (idx >= SCL_IDX_DIV_FIRST) && (idx <= SCL_IDX_DIV_LAST);
  endfunction : in_div_range

  ////////////////////////////////////////////////////////////
  // bus sequencing

  always_comb begin
    bus_d = bus_q;
    case (bus_q)
      SCL_BUS_IDLE: begin
        if (wb_cyc_i && wb_stb_i) begin
          bus_d = SCL_BUS_FETCH;
        end
      end
      SCL_BUS_FETCH: begin
        bus_d = SCL_BUS_ACK;
      end
      SCL_BUS_ACK: begin
        bus_d = SCL_BUS_IDLE;
      end
      default: begin
        bus_d = SCL_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      bus_q <= SCL_BUS_IDLE;
    end else begin
      bus_q <= bus_d;
    end
  end

  // request capture
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      idx_q <= 6'h00;
      we_q <= 1'b0;
      wdat_q <= 32'h0000_0000;
      lane0_q <= 1'b0;
    end else if (bus_q == SCL_BUS_IDLE && wb_cyc_i && wb_stb_i) begin
      idx_q <= wb_adr_i[7:2];
      we_q <= wb_we_i;
      wdat_q <= wb_dat_i;
      lane0_q <= wb_sel_i[0];
    end
  end

  // write strobe in the acknowledge-setting cycle
  assign wr_hit = (bus_q == SCL_BUS_FETCH) && we_q && lane0_q;

  ////////////////////////////////////////////////////////////
  // acknowledge and read data

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= (bus_q == SCL_BUS_FETCH);
    end
  end

  // read mux
  always_comb begin
    rdat = 32'h0000_0000;
    if (idx_q == SCL_IDX_CTRL) begin
      rdat[7:0] = ctrl_q;
    end else if (idx_q == SCL_IDX_OSC) begin
      rdat[SCL_OSC_EN_BIT] = osc_en_q;
      rdat[SCL_OSC_DIV_LSB +: 3] = osc_div_q;
    end else if (idx_q == SCL_IDX_IRQ_STAT) begin
      rdat[SCL_NIRQ-1:0] = irq_stat_q;
    end else if (idx_q == SCL_IDX_IRQ_MASK) begin
      rdat[SCL_NIRQ-1:0] = irq_mask_q;
    end else if (idx_q == SCL_IDX_LOCK_CFG) begin
      rdat[0] = lock_pin_en_q;
    end else if (idx_q == SCL_IDX_STATUS) begin
      rdat[0] = lock_sync_q;
      rdat[1] = rx_enable;
      rdat[2] = clk_run;
    end else if (in_div_range(idx_q)) begin
      rdat[7:0] = mem_rd;
    end else if (idx_q == SCL_IDX_FREQ) begin
      rdat[15:0] = synth_cfg.loop_count;
      rdat[23:16] = synth_cfg.ref_div;
    end else begin
      rdat = 32'h0000_0000;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_q == SCL_BUS_FETCH && !we_q) begin
      wb_dat_o <= rdat;
    end else begin
      wb_dat_o <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////
  // configuration registers

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= SCL_CTRL_RESET;
    end else if (wr_hit && idx_q == SCL_IDX_CTRL) begin
      ctrl_q <= wdat_q[7:0];
    end
  end

  // clock output enable is set by reset
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      osc_en_q <= SCL_OSC_RESET[SCL_OSC_EN_BIT];
      osc_div_q <= SCL_OSC_RESET[SCL_OSC_DIV_LSB +: 3];
    end else if (wr_hit && idx_q == SCL_IDX_OSC) begin
      osc_en_q <= wdat_q[SCL_OSC_EN_BIT];
      osc_div_q <= wdat_q[SCL_OSC_DIV_LSB +: 3];
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      lock_pin_en_q <= 1'b0;
    end else if (wr_hit && idx_q == SCL_IDX_LOCK_CFG) begin
      lock_pin_en_q <= wdat_q[0];
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      irq_mask_q <= '0;
    end else if (wr_hit && idx_q == SCL_IDX_IRQ_MASK) begin
      irq_mask_q <= wdat_q[SCL_NIRQ-1:0];
    end
  end

  ////////////////////////////////////////////////////////////
  // divider sets

  // read address leads while idle, so the byte stands by the fetch cycle
  always_comb begin
    if (bus_q == SCL_BUS_IDLE) begin
      mem_idx = wb_adr_i[7:2];
    end else begin
      mem_idx = idx_q;
    end
  end

  assign mem_addr = 3'(mem_idx - SCL_IDX_DIV_FIRST);
  assign mem_wr = wr_hit && in_div_range(idx_q);

  scl_div_mem u_div_mem (
    .clock(clock),
    .reset_n(reset_n),
    .wr_en(mem_wr),
    .addr(mem_addr),
    .wr_data(wdat_q[7:0]),
    .rd_data(mem_rd),
    .set_sel(ctrl_q.set_sel),
    .active_set(act_set)
  );

  // synthesizer word from the active set, band and trim from the control register
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      synth_cfg <= '0;
    end else begin
      synth_cfg.ref_div <= act_set.ref_div;
      synth_cfg.loop_count <= scl_loop_count(act_set.main_div,
                                             act_set.fine_div);
      synth_cfg.band_select_field <= ctrl_q.band_select_field;
      synth_cfg.tank_trim_field <= ctrl_q.tank_trim_field;
    end
  end

  ////////////////////////////////////////////////////////////
  // operating mode

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rx_enable <= 1'b0;
      sleep_mode <= 1'b1;
    end else begin
      rx_enable <= (ctrl_q.operating_mode_field == SCL_MODE_RX);
      sleep_mode <= (ctrl_q.operating_mode_field == SCL_MODE_SLEEP);
    end
  end

  ////////////////////////////////////////////////////////////
  // clock output

  // stopped in sleep
  assign clk_run = osc_en_q
                   && (ctrl_q.operating_mode_field != SCL_MODE_SLEEP);

  scl_clkout_div u_clkout_div (
    .clock(clock),
    .reset_n(reset_n),
    .run(clk_run),
    .ratio_sel(osc_div_q),
    .tick(clk_tick)
  );

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      clk_out <= 1'b0;
    end else if (!clk_run) begin
      clk_out <= 1'b0;
    end else if (clk_tick) begin
      clk_out <= !clk_out;
    end
  end

  ////////////////////////////////////////////////////////////
  // lock synchroniser

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      lock_meta_q <= 1'b0;
      lock_sync_q <= 1'b0;
      lock_prev_q <= 1'b0;
    end else begin
      lock_meta_q <= synth_lock_raw;
      lock_sync_q <= lock_meta_q;
      lock_prev_q <= lock_sync_q;
    end
  end

  // lock indicator pin
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      lock_pin <= 1'b0;
    end else begin
      lock_pin <= lock_pin_en_q && lock_sync_q;
    end
  end

  ////////////////////////////////////////////////////////////
  // sticky flags and interrupt

  assign irq_evt[SCL_IRQ_LOCK] = lock_sync_q && !lock_prev_q;
  assign irq_evt[SCL_IRQ_LOSS] = !lock_sync_q && lock_prev_q;
  assign irq_clr = (wr_hit && idx_q == SCL_IDX_IRQ_STAT)
                   ? wdat_q[SCL_NIRQ-1:0] : '0;

  // set beats clear
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_evt;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((irq_stat_q & ~irq_clr) | irq_evt) & irq_mask_q);
    end
  end

endmodule : scl_synth_ctrl
`default_nettype wire

// file: sim/scl_synth_ctrl_chk.sv
// port assertions for the synthesizer control block
`timescale 1ns/1ps
`default_nettype none
module scl_synth_ctrl_chk (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [scl_pkg::SCL_DW-1:0] wb_dat_o,
  input wire logic wb_ack_o,
  // synthesizer and pins
  input wire logic synth_lock_raw,
  input wire logic rx_enable,
  input wire logic sleep_mode,
  input wire logic clk_out,
  input wire logic lock_pin,
  input wire logic irq
);
  import scl_pkg::*;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  ////////////////////
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == '0)
    else $error("read data outside ack");
  sleep_stop_a: assert property (sleep_mode [*3] |-> !clk_out)
    else $error("clock output runs in sleep");
  mode_excl_a: assert property (!(rx_enable && sleep_mode))
    else $error("receive and sleep together");
  mode_src_a: assert property (($changed(rx_enable) || $changed(sleep_mode))
    |-> wb_ack_o || $past(wb_ack_o) || $past(wb_ack_o, 2))
    else $error("mode changed without write");
  lock_pin_a: assert property (lock_pin |-> $past(synth_lock_raw, 3))
    else $error("lock pin without lock");
  irq_rise_a: assert property ($rose(irq) |-> wb_ack_o || $past(wb_ack_o) || $past(wb_ack_o, 2)
    || ($past(synth_lock_raw, 3) != $past(synth_lock_raw, 4)))
    else $error("irq rose without cause");
  irq_fall_a: assert property ($fell(irq) |-> wb_ack_o || $past(wb_ack_o) || $past(wb_ack_o, 2))
    else $error("irq fell without write");
endmodule : scl_synth_ctrl_chk
bind scl_synth_ctrl scl_synth_ctrl_chk scl_synth_ctrl_chk_inst (.clock(clock), .reset_n(reset_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .synth_lock_raw(synth_lock_raw), .rx_enable(rx_enable), .sleep_mode(sleep_mode),
  .clk_out(clk_out), .lock_pin(lock_pin), .irq(irq));
`default_nettype wire

// file: sim/tb.sv
// testbench for the synthesizer control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import scl_pkg::*;
  logic clock, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, synth_lock_raw;
  logic wb_ack_o, rx_enable, sleep_mode, clk_out, lock_pin, irq;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rdv;
  logic [15:0] lc;
  logic [7:0] dv [6];
  logic [1:0] bd [3];
  scl_synth_cfg_t synth_cfg;
  int err_count, n_checks, hi, lo;
  scl_synth_ctrl scl_synth_ctrl_inst (.clock(clock), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .synth_lock_raw(synth_lock_raw),
    .synth_cfg(synth_cfg), .rx_enable(rx_enable), .sleep_mode(sleep_mode), .clk_out(clk_out),
    .lock_pin(lock_pin), .irq(irq));
  ////////////////////
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clock);
    while (wb_ack_o !== 1'b1) begin
      @(posedge clock);
    end
    rdv = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clock);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, rdv, e);
  endtask : rd
  task automatic meas();
    int n;
    n = 0;
    hi = 0;
    lo = 0;
    while (clk_out !== 1'b1 && n < 300) begin
      @(posedge clock);
      n++;
    end
    while (clk_out === 1'b1 && hi < 300) begin
      @(posedge clock);
      hi++;
    end
    while (clk_out !== 1'b1 && lo < 300) begin
      @(posedge clock);
      lo++;
    end
  endtask : meas
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up
  ////////////////////
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  initial begin
    repeat (40000) @(posedge clock);
    err_count++;
    wrap_up();
  end
  initial begin
    {reset_n, wb_cyc_i, wb_stb_i, wb_we_i, synth_lock_raw} = '0;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0;
    wb_sel_i = 4'hF;
    err_count = 0;
    n_checks = 0;
    dv = '{8'h77, 8'h5A, 8'h20, 8'hA9, 8'h40, 8'h3F};
    bd = '{2'b10, 2'b00, 2'b01};
    repeat (16) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    chk("sleep", sleep_mode, 1'b1);
    rd(8'h04, 32'h1, "osc");
    rd(8'h3C, 32'h0, "unmapped");
    wr(8'h00, 32'h1);
    chk("awake", sleep_mode, 1'b0);
    chk("rx", rx_enable, 1'b0);
    for (int d = 0; d < 8; d++) begin
      wr(8'h04, 32'(d * 2 + 1));
      meas();
      meas();
      chk("period", 32'(hi + lo), 32'(2 ** (d + 1)));
    end
    wr(8'h04, 32'h6);
    meas();
    chk("off", 32'(hi), 32'h0);
    wr(8'h04, 32'h1);
    wr(8'h00, 32'h0);
    meas();
    chk("slept", 32'(hi), 32'h0);
    wb_sel_i <= 4'hE;
    wr(8'h04, 32'h0);
    wb_sel_i <= 4'hF;
    rd(8'h04, 32'h1, "sel");
    for (int i = 0; i < 3; i++) begin
      wr(8'h00, 32'({i[1:0], bd[i], 3'b011}));
      chk("rx", rx_enable, 1'b1);
      chk("band", synth_cfg.band_select_field, bd[i]);
      chk("trim", synth_cfg.tank_trim_field, i[1:0]);
      rd(8'h14, 32'h6, "stat");
    end
    for (int i = 0; i < 6; i++) begin
      wr(8'(8'h18 + 4 * i), 32'(dv[i]));
    end
    for (int i = 0; i < 6; i++) begin
      rd(8'(8'h18 + 4 * i), 32'(dv[i]), "div");
    end
    for (int s = 0; s < 2; s++) begin
      wr(8'h00, 32'({s[0], 7'h03}));
      lc = 16'(75 * (dv[3 * s + 1] + 1) + dv[3 * s + 2]);
      rd(8'h30, {8'h0, dv[3 * s], lc}, "freq");
      chk("cfg", {8'h0, synth_cfg.ref_div, synth_cfg.loop_count}, {8'h0, dv[3 * s], lc});
    end
    wr(8'h0C, 32'h1);
    wr(8'h10, 32'h1);
    synth_lock_raw <= 1'b1;
    repeat (6) @(posedge clock);
    chk("pin", lock_pin, 1'b1);
    chk("irq", irq, 1'b1);
    rd(8'h08, 32'h1, "flag");
    synth_lock_raw <= 1'b0;
    repeat (6) @(posedge clock);
    chk("pin", lock_pin, 1'b0);
    rd(8'h08, 32'h3, "held");
    wr(8'h08, 32'h0);
    rd(8'h08, 32'h3, "w0");
    wr(8'h08, 32'h1);
    rd(8'h08, 32'h2, "w1");
    chk("irq", irq, 1'b0);
    wr(8'h10, 32'h0);
    synth_lock_raw <= 1'b1;
    repeat (6) @(posedge clock);
    chk("pin", lock_pin, 1'b0);
    chk("irq", irq, 1'b1);
    wr(8'h0C, 32'h0);
    chk("irq", irq, 1'b0);
    wrap_up();
  end
endmodule : tb
`default_nettype wire
